// >>> core/tpit_defines.svh
// Constants for the triple interval timer: addresses, mode byte fields, rates.
// Included by the timer top; defines only.
`ifndef TPIT_DEFINES_SVH
`define TPIT_DEFINES_SVH

// Memory map: three counter locations, then the mode byte location
`define TPIT_ADDR_CTR0      16'hD100
`define TPIT_ADDR_MODE      16'hD103
`define TPIT_IDX_MODE       2'h3
`define TPIT_READ_MODE_LOC  8'hFF
`define TPIT_READ_UNMAPPED  8'h00

// Mode byte field positions
`define TPIT_SEL_HI         7
`define TPIT_SEL_LO         6
`define TPIT_ACC_HI         5
`define TPIT_ACC_LO         4
`define TPIT_MODE_HI        3
`define TPIT_MODE_LO        1
`define TPIT_BCD_BIT        0
`define TPIT_SEL_UNUSED     2'h3

// Counter geometry
`define TPIT_CTR_WIDTH      16
`define TPIT_CTR_COUNT      3

// Count rate derived from the system clock
`define TPIT_SYS_CLK_HZ     10000000
`define TPIT_COUNT_HZ       2000000
`define TPIT_TICK_CYCLES    (`TPIT_SYS_CLK_HZ / `TPIT_COUNT_HZ)

// Reset values
`define TPIT_RST_COUNT      16'h0000
`define TPIT_RST_BYTE       8'h00

`endif

// >>> core/tpit_pkg.sv
// Types for the triple interval timer: operating modes and byte access codes.
// Used by the timer top; no state.
package tpit_pkg;

  // Normalised operating mode held per counter
  typedef enum logic [2:0] {
    TPIT_MODE0 = 3'h0,
    TPIT_MODE1 = 3'h1,
    TPIT_MODE2 = 3'h2,
    TPIT_MODE3 = 3'h3,
    TPIT_MODE4 = 3'h4,
    TPIT_MODE5 = 3'h5
  } tpit_mode_type;

  // Read/load field of the mode byte
  typedef enum logic [1:0] {
    TPIT_ACC_LATCH = 2'h0,
    TPIT_ACC_LOW   = 2'h1,
    TPIT_ACC_HIGH  = 2'h2,
    TPIT_ACC_BOTH  = 2'h3
  } tpit_access_type;

endpackage : tpit_pkg

// >>> core/tpit_count_step.sv
// Down-count step for one timer counter, binary or four-decade BCD.
// Purely combinational; the caller holds the count.
`timescale 1ns/10ps

module tpit_count_step (
  // Operand
  input  wire logic [15:0] value,
  input  wire logic        bcd,
  input  wire logic [1:0]  amount,
  // Result
  output logic      [15:0] result
);

  // Digit-serial borrow chain, replaced by plain subtraction in binary
  always_comb begin : step
    logic [4:0] digit;
    logic [4:0] take;
    digit  = 5'h00;
    take   = {3'h0, amount};
    result = 16'h0000;
    for (int d = 0; d < 4; d++) begin
      digit = {1'b0, value[4*d +: 4]} - take;
      if (digit[4]) begin
        digit = digit + 5'h0A;
        take  = 5'h01;
      end else begin
        take  = 5'h00;
      end
      result[4*d +: 4] = digit[3:0];
    end
    if (!bcd) begin
      result = value - {14'h0000, amount};
    end
  end

endmodule : tpit_count_step

// >>> core/tpit_timer.sv
// Triple programmable interval timer: three 16-bit down counters behind four
// memory-mapped byte locations. Assumes a synchronous byte bus with one-cycle
// read and write strobes, and gates and switches synchronous to sys_clk.
`timescale 1ns/10ps
`include "tpit_defines.svh"

module tpit_timer #(
  parameter int TICK_DIV = `TPIT_TICK_CYCLES
) (
  // Clock, reset, clock enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Memory-mapped byte bus
  input  wire logic       map_enable,
  input  wire logic [15:0] bus_addr,
  input  wire logic       bus_rd,
  input  wire logic       bus_wr,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  // Counter gates and outputs
  input  wire logic [2:0] timer_gate,
  output logic      [2:0] timer_out,
  // Option switches
  input  wire logic       ctr1_irq_switch,
  input  wire logic       ctr2_irq_switch,
  input  wire logic       cascade_from_ctr1_switch,
  input  wire logic       ctr2_base_clock_switch,
  // Interrupt request
  output logic            timer_irq
);

  localparam int NCTR = `TPIT_CTR_COUNT;

  // Refuse a divider the prescaler cannot build
  if (TICK_DIV < 1 || TICK_DIV > 255) begin : g_bad_div
    $error("TICK_DIV must lie in 1..255");
  end

  // Map a raw mode field onto the six operating modes
  function automatic tpit_pkg::tpit_mode_type decode_mode(input logic [2:0] f);
    if (f[1]) begin
      decode_mode = f[0] ? tpit_pkg::TPIT_MODE3 : tpit_pkg::TPIT_MODE2;
    end else begin
      decode_mode = tpit_pkg::tpit_mode_type'({f[2], 1'b0, f[0]});
    end
  endfunction : decode_mode

  // Shared per-counter state
  logic [15:0]               cnt     [NCTR];
  logic [15:0]               init    [NCTR];
  logic [15:0]               latch   [NCTR];
  logic [15:0]               period  [NCTR];
  logic [15:0]               nxt     [NCTR];
  tpit_pkg::tpit_mode_type   mode    [NCTR];
  tpit_pkg::tpit_access_type acc     [NCTR];
  logic [NCTR-1:0]           bcd;
  logic [NCTR-1:0]           latched;
  logic [NCTR-1:0]           wr_hi;
  logic [NCTR-1:0]           rd_hi;
  logic [NCTR-1:0]           out;
  logic [NCTR-1:0]           run;
  logic [NCTR-1:0]           pend;
  logic [NCTR-1:0]           trig;
  logic [NCTR-1:0]           gate_q;
  logic [NCTR-1:0]           tick;
  logic [7:0]                div_cnt;
  logic                      base_tick;
  logic                      out1_q;
  logic [7:0]                rd_byte [NCTR];

  // Address decode
  wire        hit      = map_enable && (bus_addr[15:2] == 14'(`TPIT_ADDR_CTR0 >> 2));
  wire [1:0]  idx      = bus_addr[1:0];
  wire [1:0]  wr_sel   = bus_wdata[`TPIT_SEL_HI:`TPIT_SEL_LO];
  wire [1:0]  wr_acc   = bus_wdata[`TPIT_ACC_HI:`TPIT_ACC_LO];
  wire        mode_wr  = hit && bus_wr && (idx == `TPIT_IDX_MODE);
  wire tpit_pkg::tpit_mode_type wr_mode =
    decode_mode(bus_wdata[`TPIT_MODE_HI:`TPIT_MODE_LO]);

  // 2 MHz base tick from prescaler
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt   <= 8'h00;
      base_tick <= 1'b0;
    end else if (ce) begin
      base_tick <= (div_cnt == 8'(TICK_DIV - 1));
      div_cnt   <= (div_cnt == 8'(TICK_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // Counter 1 output edge for cascading
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out1_q <= 1'b1;
    end else if (ce) begin
      out1_q <= out[1];
    end
  end

  assign tick[0] = base_tick;
  assign tick[1] = base_tick;
  assign tick[2] = ctr2_base_clock_switch ? base_tick :
                   (cascade_from_ctr1_switch && out[1] && !out1_q);

  for (genvar i = 0; i < NCTR; i++) begin : g_ctr
    wire sel_me     = mode_wr && (wr_sel == 2'(i)) && (wr_sel != `TPIT_SEL_UNUSED);
    wire cmd_latch  = sel_me && (wr_acc == tpit_pkg::TPIT_ACC_LATCH);
    wire cmd_mode   = sel_me && (wr_acc != tpit_pkg::TPIT_ACC_LATCH);
    wire cnt_wr     = hit && bus_wr && (idx == 2'(i));
    wire cnt_rd     = hit && bus_rd && (idx == 2'(i));
    wire two_byte   = (acc[i] == tpit_pkg::TPIT_ACC_BOTH);
    wire load_done  = cnt_wr && (!two_byte || wr_hi[i]);
    wire first_byte = cnt_wr && two_byte && !wr_hi[i];
    wire read_done  = cnt_rd && (!two_byte || rd_hi[i]);
    wire gate       = timer_gate[i];
    wire terminal   = (nxt[i] == 16'h0000);
    wire [15:0] src = latched[i] ? latch[i] : cnt[i];
    wire hi_sel     = (acc[i] == tpit_pkg::TPIT_ACC_HIGH) || (two_byte && rd_hi[i]);
    // Square wave steps by two, odd counts take one extra tick high and one fewer low
    wire [1:0] amt  = (mode[i] != tpit_pkg::TPIT_MODE3) ? 2'h1 :
                      (!cnt[i][0] ? 2'h2 : (out[i] ? 2'h1 : 2'h3));

    assign rd_byte[i] = hi_sel ? src[15:8] : src[7:0];

    tpit_count_step u_step (
      .value  (cnt[i]),
      .bcd    (bcd[i]),
      .amount (amt),
      .result (nxt[i])
    );

    // Bus side: mode byte, count register, read latch and byte pointers
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        mode[i]    <= tpit_pkg::TPIT_MODE0;
        acc[i]     <= tpit_pkg::TPIT_ACC_BOTH;
        bcd[i]     <= 1'b0;
        init[i]    <= `TPIT_RST_COUNT;
        latch[i]   <= `TPIT_RST_COUNT;
        latched[i] <= 1'b0;
        wr_hi[i]   <= 1'b0;
        rd_hi[i]   <= 1'b0;
      end else if (ce) begin
        if (cmd_mode) begin
          mode[i]    <= wr_mode;
          acc[i]     <= tpit_pkg::tpit_access_type'(wr_acc);
          bcd[i]     <= bus_wdata[`TPIT_BCD_BIT];
          latched[i] <= 1'b0;
          wr_hi[i]   <= 1'b0;
          rd_hi[i]   <= 1'b0;
        end else if (cmd_latch && !latched[i]) begin
          latch[i]   <= cnt[i];
          latched[i] <= 1'b1;
          rd_hi[i]   <= 1'b0;
        end else if (cnt_wr) begin
          unique case (acc[i])
            tpit_pkg::TPIT_ACC_LOW:  init[i] <= {8'h00, bus_wdata};
            tpit_pkg::TPIT_ACC_HIGH: init[i] <= {bus_wdata, 8'h00};
            default: begin
              if (wr_hi[i]) begin
                init[i][15:8] <= bus_wdata;
              end else begin
                init[i][7:0]  <= bus_wdata;
              end
              wr_hi[i] <= !wr_hi[i];
            end
          endcase
        end else if (cnt_rd) begin
          if (two_byte) begin
            rd_hi[i] <= !rd_hi[i];
          end
          if (read_done) begin
            latched[i] <= 1'b0;
          end
        end
      end
    end

    // Count side: counter, output and trigger tracking
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        cnt[i]    <= `TPIT_RST_COUNT;
        period[i] <= `TPIT_RST_COUNT;
        out[i]    <= 1'b1;
        run[i]    <= 1'b0;
        pend[i]   <= 1'b0;
        trig[i]   <= 1'b0;
        gate_q[i] <= 1'b0;
      end else if (ce) begin
        gate_q[i] <= gate;
        // Edge caught at any cycle, held until the next tick
        trig[i]   <= (trig[i] && !tick[i]) || (gate && !gate_q[i]);
        if (cmd_mode) begin
          // mode 2 holds high until loaded
          out[i]  <= (wr_mode != tpit_pkg::TPIT_MODE0);
          run[i]  <= 1'b0;
          pend[i] <= 1'b0;
        end else if (load_done && mode[i] == tpit_pkg::TPIT_MODE0) begin
          out[i] <= 1'b0;
          run[i] <= 1'b0;
        end else if (first_byte && mode[i] == tpit_pkg::TPIT_MODE0) begin
          run[i] <= 1'b0;
        end else if (tick[i]) begin
          unique case (mode[i])
            tpit_pkg::TPIT_MODE0: begin
              if (pend[i]) begin
                cnt[i]  <= init[i];
                run[i]  <= 1'b1;
                pend[i] <= 1'b0;
              end else if (run[i] && gate) begin
                cnt[i] <= nxt[i];
                if (terminal) begin
                  out[i] <= 1'b1;
                end
              end
            end
            tpit_pkg::TPIT_MODE1: begin
              // new value used at trigger only
              if (trig[i]) begin
                cnt[i] <= init[i];
                out[i] <= 1'b0;
                run[i] <= 1'b1;
              end else if (run[i]) begin
                cnt[i] <= nxt[i];
                if (terminal) begin
                  out[i] <= 1'b1;
                  run[i] <= 1'b0;
                end
              end
            end
            tpit_pkg::TPIT_MODE2, tpit_pkg::TPIT_MODE3: begin
              if (!gate) begin
                out[i] <= 1'b1;
                if (run[i]) begin
                  pend[i] <= 1'b1;
                  run[i]  <= 1'b0;
                end
              end else if (pend[i] && !run[i]) begin
                cnt[i]    <= init[i];
                period[i] <= init[i];
                out[i]    <= 1'b1;
                run[i]    <= 1'b1;
                pend[i]   <= 1'b0;
              end else if (run[i] && mode[i] == tpit_pkg::TPIT_MODE2) begin
                cnt[i] <= (cnt[i] == 16'h0001) ? init[i] : nxt[i];
                out[i] <= (cnt[i] != 16'h0002);
              end else if (run[i]) begin
                if (terminal) begin
                  out[i] <= !out[i];
                  cnt[i] <= out[i] ? period[i] : init[i];
                  if (!out[i]) begin
                    period[i] <= init[i];
                  end
                end else begin
                  cnt[i] <= nxt[i];
                end
              end
            end
            tpit_pkg::TPIT_MODE4: begin
              out[i] <= 1'b1;
              // reload waits for period end or gate low
              if (pend[i] && (!run[i] || !gate)) begin
                cnt[i]  <= init[i];
                run[i]  <= 1'b1;
                pend[i] <= 1'b0;
              end else if (run[i] && gate) begin
                cnt[i] <= nxt[i];
                if (terminal) begin
                  out[i] <= 1'b0;
                  run[i] <= 1'b0;
                end
              end
            end
            tpit_pkg::TPIT_MODE5: begin
              out[i] <= 1'b1;
              if (trig[i]) begin
                cnt[i] <= init[i];
                run[i] <= 1'b1;
              end else if (run[i]) begin
                cnt[i] <= nxt[i];
                if (terminal) begin
                  out[i] <= 1'b0;
                  run[i] <= 1'b0;
                end
              end
            end
            default: begin
              run[i] <= 1'b0;
            end
          endcase
        end
        // Pending load after the tick, so a same-cycle clear loses
        if (load_done) begin
          pend[i] <= 1'b1;
        end
      end
    end
  end

  // read data, mode location reads all ones
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_rdata <= `TPIT_RST_BYTE;
    end else if (ce && bus_rd) begin
      if (!hit) begin
        bus_rdata <= `TPIT_READ_UNMAPPED;
      end else if (idx == `TPIT_IDX_MODE) begin
        bus_rdata <= `TPIT_READ_MODE_LOC;
      end else begin
        bus_rdata <= rd_byte[idx];
      end
    end
  end

  // switchable interrupt from counters 1 and 2
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_irq <= 1'b0;
    end else if (ce) begin
      timer_irq <= (ctr1_irq_switch && out[1]) || (ctr2_irq_switch && out[2]);
    end
  end

  assign timer_out = out;

endmodule : tpit_timer

// >>> verification/tpit_timer_sva.sv
// Port-level checker for the triple interval timer, bound to its top.
// Assumes ce is high whenever reset is applied.
`timescale 1ns/10ps

module tpit_timer_sva #(
  parameter int TICK_DIV = 5
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  // Byte bus
  input wire logic        map_enable,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  // Counters and interrupt
  input wire logic [2:0]  timer_gate,
  input wire logic [2:0]  timer_out,
  input wire logic        ctr1_irq_switch,
  input wire logic        ctr2_irq_switch,
  input wire logic        timer_irq
);
  logic [2:0] op_mode [3];
  logic [2:0] armed;
  logic [2:0] m0_idle;
  logic [2:0] m2_idle;
  logic [2:0] m4_idle;
  logic [2:0] pulse_mode;
  int         low_len [2];

  // Decode of taken writes
  wire       taken    = ce && map_enable && bus_wr;
  wire       mode_wr  = taken && bus_addr == 16'hD103 && bus_wdata[7:6] != 2'h3
                        && bus_wdata[5:4] != 2'h0;
  wire       cnt_wr   = taken && bus_addr >= 16'hD100 && bus_addr <= 16'hD102;
  wire [2:0] new_mode = bus_wdata[2] ? {1'b0, bus_wdata[2:1]} : bus_wdata[3:1];

  // Mode set and not yet loaded, per counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      armed <= 3'h0;
    end else begin
      if (cnt_wr) armed[bus_addr[1:0]] <= 1'b0;
      if (mode_wr) begin
        armed[bus_wdata[7:6]] <= 1'b1;
        op_mode[bus_wdata[7:6]] <= new_mode;
      end
    end
  end

  // Length of the current low phase, counters 0 and 1
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (timer_out[i]) low_len[i] <= 0;
      else if (ce) low_len[i] <= low_len[i] + 1;
    end
  end

  // Mode classes
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      m0_idle[i] = armed[i] && op_mode[i] == 3'h0;
      m2_idle[i] = armed[i] && op_mode[i] == 3'h2;
      m4_idle[i] = armed[i] && op_mode[i] == 3'h4;
      pulse_mode[i] = op_mode[i] == 3'h2 || op_mode[i] == 3'h4 || op_mode[i] == 3'h5;
    end
  end

  default clocking sva_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // interrupt from outputs 1 and 2
  AST_IRQ_FOLLOWS: assert property (
    !$past(rst) && $past(ce) |-> timer_irq ==
      $past((ctr1_irq_switch && timer_out[1]) || (ctr2_irq_switch && timer_out[2])))
    else $error("interrupt does not follow counter outputs");
  AST_MODE_READS_ONES: assert property (
    ce && map_enable && bus_rd && bus_addr == 16'hD103 |=> bus_rdata == 8'hFF)
    else $error("mode location read is not FF");
  AST_UNMAPPED_ZERO: assert property (
    ce && bus_rd && (!map_enable || bus_addr < 16'hD100 || bus_addr > 16'hD103)
    |=> bus_rdata == 8'h00)
    else $error("unmapped read is not 00");
  AST_RDATA_STANDS: assert property (
    !(ce && bus_rd) |=> $stable(bus_rdata))
    else $error("read data changed without a read");
  AST_M0_SET_LOW: assert property ((m0_idle & timer_out) == 3'h0)
    else $error("mode 0 output not low after mode set");
  AST_M2_SET_HIGH: assert property ((m2_idle & ~timer_out) == 3'h0)
    else $error("mode 2 output low before count load");
  AST_M4_SET_HIGH: assert property ((m4_idle & ~timer_out) == 3'h0)
    else $error("mode 4 output low after mode set");
  AST_PULSE_ONE_TICK: assert property (
    !((pulse_mode[0] && !timer_out[0] && low_len[0] >= TICK_DIV) ||
      (pulse_mode[1] && !timer_out[1] && low_len[1] >= TICK_DIV)))
    else $error("strobe low longer than one count period");
  AST_RESET_LEVELS: assert property (disable iff (1'b0)
    rst && ce |=> timer_out == 3'h7 && !timer_irq && bus_rdata == 8'h00)
    else $error("reset levels wrong");

  // Main scenarios reached
  cover property ($fell(timer_out[1]));
  cover property ($rose(timer_irq));
  cover property ($fell(timer_out[2]));
endmodule : tpit_timer_sva

bind tpit_timer tpit_timer_sva #(.TICK_DIV(TICK_DIV)) u_sva (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .map_enable(map_enable), .bus_addr(bus_addr),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .timer_gate(timer_gate), .timer_out(timer_out), .ctr1_irq_switch(ctr1_irq_switch),
  .ctr2_irq_switch(ctr2_irq_switch), .timer_irq(timer_irq)
);

// >>> verification/tpit_host.sv
// Host processor model: byte reads and writes on the timer's mapped bus.
// Drives on falling edges; the timer takes strobes on rising edges.
`timescale 1ns/10ps

module tpit_host (
  // Clock
  input  wire logic        sys_clk,
  // Byte bus toward the timer
  output logic             map_enable,
  output logic [15:0]      bus_addr,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic [7:0]       bus_wdata,
  input  wire logic [7:0]  bus_rdata
);
  // Idle bus at time zero
  initial begin
    map_enable = 1'b1;
    bus_addr = 16'h0000;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
  end

  task automatic xfer(input logic rd, input logic [15:0] a, input logic [7:0] d,
                      input logic en, output logic [7:0] q);
    @(negedge sys_clk);
    map_enable = en;
    bus_addr = a;
    bus_wdata = d;
    bus_rd = rd;
    bus_wr = !rd;
    @(negedge sys_clk);
    q = bus_rdata;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
    map_enable = 1'b1;
  endtask : xfer

  // park every counter on a short count
  task automatic program_all();
    logic [7:0] q;
    for (int c = 0; c < 3; c++) begin
      xfer(1'b0, 16'hD103, {2'(c), 6'h10}, 1'b1, q);
      xfer(1'b0, 16'hD100 + 16'(c), 8'h01, 1'b1, q);
    end
  endtask : program_all
endmodule : tpit_host

// >>> verification/tpit_timer_bench.sv
// Self-checking bench for the triple interval timer with a host model.
// The base tick fires every system clock to keep the run short.
`timescale 1ns/10ps

module tpit_timer_bench;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [2:0]  timer_gate = 3'h0;
  logic        ctr1_irq_switch = 1'b0;
  logic        ctr2_irq_switch = 1'b0;
  logic        cascade_from_ctr1_switch = 1'b0;
  logic        ctr2_base_clock_switch = 1'b1;
  logic        map_enable, bus_rd, bus_wr, timer_irq;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, q;
  logic [2:0]  timer_out;
  int          failures = 0;
  int          n_checks = 0;
  int          lows, falls;
  logic [7:0]  tb_mb [5] = '{8'h74, 8'h7C, 8'h36, 8'h3E, 8'h36};
  int          tb_ctr [5] = '{1, 1, 0, 0, 0};
  int          tb_n [5] = '{4, 4, 5, 5, 4};
  int          tb_low [5] = '{10, 10, 16, 16, 20};
  int          tb_fall [5] = '{10, 10, 8, 8, 10};

  // Clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  tpit_timer #(.TICK_DIV(1)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .map_enable(map_enable), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .timer_gate(timer_gate), .timer_out(timer_out), .ctr1_irq_switch(ctr1_irq_switch),
    .ctr2_irq_switch(ctr2_irq_switch), .cascade_from_ctr1_switch(cascade_from_ctr1_switch),
    .ctr2_base_clock_switch(ctr2_base_clock_switch), .timer_irq(timer_irq)
  );

  tpit_host u_host (
    .sys_clk(sys_clk), .map_enable(map_enable), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata)
  );

  // Verdict and end of run
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, 1'b1, q);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    u_host.xfer(1'b1, a, 8'h00, 1'b1, q);
    check({8'h00, q}, {8'h00, exp});
  endtask : rd

  task automatic load2(input logic [15:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask : load2

  // Count low samples and falling edges of one output
  task automatic meas(input int idx, input int len);
    logic prev;
    lows = 0;
    falls = 0;
    @(negedge sys_clk);
    prev = timer_out[idx];
    repeat (len) begin
      @(negedge sys_clk);
      if (!timer_out[idx]) lows++;
      if (prev && !timer_out[idx]) falls++;
      prev = timer_out[idx];
    end
  endtask : meas

  // Watchdog
  initial begin
    #2000000;
    failures++;
    wrap_up();
  end

  // Test sequence
  initial begin
    cyc(8);
    rst = 1'b0;
    check({13'h0, timer_out}, 16'h0007);
    rd(16'hD103, 8'hFF);
    rd(16'hD0FF, 8'h00);
    u_host.program_all();
    wr(16'hD103, 8'h30);
    load2(16'hD100, 16'h1234);
    u_host.xfer(1'b0, 16'hD100, 8'h55, 1'b0, q);
    rd(16'hD100, 8'h34);
    rd(16'hD100, 8'h12);
    wr(16'hD103, 8'h00);
    timer_gate[0] = 1'b1;
    cyc(6);
    rd(16'hD100, 8'h34);
    rd(16'hD100, 8'h12);
    timer_gate[0] = 1'b0;
    u_host.xfer(1'b1, 16'hD100, 8'h00, 1'b1, q);
    check({15'h0, q < 8'h34}, 16'h0001);
    rd(16'hD100, 8'h12);
    wr(16'hD103, 8'h50);
    wr(16'hD101, 8'h07);
    rd(16'hD101, 8'h07);
    wr(16'hD103, 8'hA0);
    wr(16'hD102, 8'h02);
    wr(16'hD103, 8'hF0);
    rd(16'hD102, 8'h02);
    wr(16'hD103, 8'h31);
    load2(16'hD100, 16'h0100);
    timer_gate[0] = 1'b1;
    cyc(4);
    timer_gate[0] = 1'b0;
    u_host.xfer(1'b1, 16'hD100, 8'h00, 1'b1, q);
    check({12'h0, q[7:4]}, 16'h0009);
    rd(16'hD100, 8'h00);
    // Mode 0: gate inhibit, halted reload, terminal count
    wr(16'hD103, 8'h30);
    load2(16'hD100, 16'h0020);
    cyc(40);
    check({15'h0, timer_out[0]}, 16'h0000);
    timer_gate[0] = 1'b1;
    cyc(4);
    wr(16'hD100, 8'h05);
    cyc(40);
    check({15'h0, timer_out[0]}, 16'h0000);
    wr(16'hD100, 8'h00);
    meas(0, 20);
    check({15'h0, lows >= 4 && lows <= 7}, 16'h0001);
    check({15'h0, timer_out[0]}, 16'h0001);
    // Modes 2 and 3, both encodings of each
    ctr1_irq_switch = 1'b1;
    timer_gate[1] = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(16'hD103, tb_mb[i]);
      cyc(6);
      if (i < 2) check({15'h0, timer_out[tb_ctr[i]]}, 16'h0001);
      load2(16'hD100 + 16'(tb_ctr[i]), 16'(tb_n[i]));
      cyc(10);
      meas(tb_ctr[i], 40);
      check(16'(lows), 16'(tb_low[i]));
      check(16'(falls), 16'(tb_fall[i]));
    end
    // Clock enable low freezes a running counter
    ce = 1'b0;
    meas(1, 12);
    check(16'(falls), 16'h0000);
    ce = 1'b1;
    // Mode 3 reload takes the new period
    load2(16'hD100, 16'h0006);
    cyc(10);
    meas(0, 24);
    check(16'(falls), 16'h0004);
    timer_gate[1] = 1'b0;
    cyc(2);
    meas(1, 12);
    check(16'(lows), 16'h0000);
    timer_gate[1] = 1'b1;
    // Mode 4 strobe, then reload while inhibited
    wr(16'hD103, 8'h38);
    load2(16'hD100, 16'h0003);
    meas(0, 15);
    check(16'(lows), 16'h0001);
    timer_gate[0] = 1'b0;
    load2(16'hD100, 16'h0003);
    meas(0, 12);
    check(16'(lows), 16'h0000);
    timer_gate[0] = 1'b1;
    meas(0, 12);
    check(16'(falls), 16'h0001);
    // Mode 1 one-shot and retrigger
    wr(16'hD103, 8'hB2);
    load2(16'hD102, 16'h0004);
    cyc(6);
    check({15'h0, timer_out[2]}, 16'h0001);
    timer_gate[2] = 1'b1;
    meas(2, 12);
    check(16'(lows), 16'h0004);
    timer_gate[2] = 1'b0;
    cyc(1);
    timer_gate[2] = 1'b1;
    cyc(2);
    timer_gate[2] = 1'b0;
    cyc(1);
    timer_gate[2] = 1'b1;
    meas(2, 14);
    check({15'h0, lows >= 3 && lows <= 5}, 16'h0001);
    // Reload during the pulse waits for the next trigger
    timer_gate[2] = 1'b0;
    cyc(1);
    timer_gate[2] = 1'b1;
    load2(16'hD102, 16'h0008);
    meas(2, 8);
    check(16'(lows), 16'h0000);
    timer_gate[2] = 1'b0;
    cyc(1);
    timer_gate[2] = 1'b1;
    meas(2, 12);
    check(16'(lows), 16'h0008);
    // Mode 5 waits for a gate edge
    timer_gate[2] = 1'b0;
    wr(16'hD103, 8'hBA);
    load2(16'hD102, 16'h0003);
    meas(2, 10);
    check(16'(lows), 16'h0000);
    timer_gate[2] = 1'b1;
    meas(2, 12);
    check(16'(lows), 16'h0001);
    // Counter 2 counting counter 1 pulses, then no clock at all
    ctr2_base_clock_switch = 1'b0;
    cascade_from_ctr1_switch = 1'b1;
    ctr2_irq_switch = 1'b1;
    wr(16'hD103, 8'hB4);
    load2(16'hD102, 16'h0002);
    cyc(20);
    meas(2, 40);
    check(16'(falls), 16'h0005);
    cascade_from_ctr1_switch = 1'b0;
    cyc(10);
    meas(2, 40);
    check(16'(falls), 16'h0000);
    // Reset again in mid-run
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    check({13'h0, timer_out}, 16'h0007);
    wrap_up();
  end
endmodule : tpit_timer_bench
